/* File: verilog/nvac_ctrl.sv */
// controller giving the core byte access to the non-volatile data array
`timescale 1ns/1ps

module nvac_ctrl
#(
    parameter logic [7:0] WRITE_TICKS = nvac_pkg::NVAC_WRITE_TICKS
)
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic sfr_bank,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic slow_clk_in,
    input wire logic irq_ack,
    output logic write_done_irq_flag,
    output logic nvm_busy
);

    typedef struct packed
    {
        nvac_pkg::nvac_fsm_t st;
        logic [4:0] nvm_address;
        logic [7:0] nvm_data;
        logic write_permit;
        logic write_start;
        logic read_permit;
        logic read_start;
        logic [7:0] cnt;
        logic [7:0] rdata;
        logic irq_flag;
        logic busy;
    } nvac_ctrl_state_t;

    nvac_ctrl_state_t r;
    nvac_ctrl_state_t next_r;

    logic slow_tick;
    logic [7:0] mem_rdata;
    logic mem_wr;
    logic mem_rd;
    logic write_commit;
    logic read_commit;
    logic hit_address;
    logic hit_data;
    logic hit_control;

    // ==========================================
    // submodules
    nvac_sync u_slow_sync
    (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .async_in(slow_clk_in),
        .rise_pulse(slow_tick)
    );

    nvac_mem u_mem
    (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .wr_en(mem_wr),
        .rd_en(mem_rd),
        .addr(r.nvm_address),
        .wdata(r.nvm_data),
        .rdata(mem_rdata)
    );

    // ==========================================
    // register decode
    // direct bank decode for address and data, control bank decode for control
    assign hit_address = (sfr_bank == nvac_pkg::NVAC_BANK_DIRECT) && (sfr_addr == nvac_pkg::NVAC_OFS_ADDRESS);
    assign hit_data = (sfr_bank == nvac_pkg::NVAC_BANK_DIRECT) && (sfr_addr == nvac_pkg::NVAC_OFS_DATA);
    assign hit_control = (sfr_bank == nvac_pkg::NVAC_BANK_CTRL) && (sfr_addr == nvac_pkg::NVAC_OFS_CONTROL);

    // ==========================================
    // next state
    always_comb
    begin
        next_r = r;
        mem_wr = 1'b0;
        mem_rd = 1'b0;
        write_commit = 1'b0;
        read_commit = 1'b0;

        // read-back; unmapped locations answer zero
        if (sfr_rd)
        begin
            next_r.rdata = 8'h00;
            if (hit_address)
                next_r.rdata = {3'h0, r.nvm_address};
            if (hit_data)
                next_r.rdata = r.nvm_data;
            if (hit_control)
            begin
                next_r.rdata[nvac_pkg::NVAC_BIT_WRITE_PERMIT] = r.write_permit;
                next_r.rdata[nvac_pkg::NVAC_BIT_WRITE_START] = r.write_start;
                next_r.rdata[nvac_pkg::NVAC_BIT_READ_PERMIT] = r.read_permit;
                next_r.rdata[nvac_pkg::NVAC_BIT_READ_START] = r.read_start;
            end
        end

        if (sfr_wr && hit_address)
            next_r.nvm_address = sfr_wdata[4:0];
        if (sfr_wr && hit_data)
            next_r.nvm_data = sfr_wdata;

        if (sfr_wr && hit_control)
        begin
            next_r.write_permit = sfr_wdata[nvac_pkg::NVAC_BIT_WRITE_PERMIT];
            next_r.read_permit = sfr_wdata[nvac_pkg::NVAC_BIT_READ_PERMIT];
            // start bits belong to hardware while a cycle runs, so zeros written then are ignored
            if (r.st == nvac_pkg::NVAC_IDLE)
            begin
                if (sfr_wdata[nvac_pkg::NVAC_BIT_WRITE_START] && r.write_permit)
                begin
                    next_r.write_start = 1'b1;
                    next_r.st = nvac_pkg::NVAC_WRITE;
                    next_r.cnt = 8'h00;
                end
                else if (sfr_wdata[nvac_pkg::NVAC_BIT_READ_START] && r.read_permit)
                begin
                    next_r.read_start = 1'b1;
                    next_r.st = nvac_pkg::NVAC_READ;
                    next_r.cnt = 8'h00;
                end
            end
        end

        case (r.st)
            nvac_pkg::NVAC_IDLE:
            begin
            end
            nvac_pkg::NVAC_READ:
            begin
                if (!r.read_permit)
                begin
                    next_r.read_start = 1'b0;
                    next_r.st = nvac_pkg::NVAC_IDLE;
                end
                else
                begin
                    mem_rd = (r.cnt == 8'h00);
                    next_r.cnt = r.cnt + 8'h01;
                    if (r.cnt == nvac_pkg::NVAC_READ_CYCLES - 8'h01)
                    begin
                        read_commit = 1'b1;
                        next_r.nvm_data = mem_rdata;
                        next_r.read_start = 1'b0;
                        next_r.st = nvac_pkg::NVAC_IDLE;
                    end
                end
            end
            nvac_pkg::NVAC_WRITE:
            begin
                if (!r.write_permit)
                begin
                    next_r.write_start = 1'b0;
                    next_r.st = nvac_pkg::NVAC_IDLE;
                end
                else if (slow_tick)
                begin
                    next_r.cnt = r.cnt + 8'h01;
                    if (r.cnt == WRITE_TICKS - 8'h01)
                    begin
                        write_commit = 1'b1;
                        mem_wr = 1'b1;
                        next_r.write_start = 1'b0;
                        next_r.st = nvac_pkg::NVAC_IDLE;
                    end
                end
            end
            default:
            begin
                next_r.write_start = 1'b0;
                next_r.read_start = 1'b0;
                next_r.st = nvac_pkg::NVAC_IDLE;
            end
        endcase

        if (irq_ack)
            next_r.irq_flag = 1'b0;
        if (write_commit)
            next_r.irq_flag = 1'b1;

        next_r.busy = (next_r.st != nvac_pkg::NVAC_IDLE);
    end

    // ==========================================
    // state register
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            r.st <= nvac_pkg::NVAC_IDLE;
            r.nvm_address <= nvac_pkg::NVAC_RST_ADDRESS;
            r.nvm_data <= nvac_pkg::NVAC_RST_DATA;
            r.write_permit <= nvac_pkg::NVAC_RST_CTRL_BIT;
            r.write_start <= nvac_pkg::NVAC_RST_CTRL_BIT;
            r.read_permit <= nvac_pkg::NVAC_RST_CTRL_BIT;
            r.read_start <= nvac_pkg::NVAC_RST_CTRL_BIT;
            r.cnt <= 8'h00;
            r.rdata <= 8'h00;
            r.irq_flag <= 1'b0;
            r.busy <= 1'b0;
        end
        else if (ce)
        begin
            r <= next_r;
        end
    end

    assign sfr_rdata = r.rdata;
    assign write_done_irq_flag = r.irq_flag;
    assign nvm_busy = r.busy;

    // ==========================================
    // checks
    default clocking ctrl_cb @(posedge clk);
    endclocking
    default disable iff (!reset_n || !ce);

    address_upper_zero_a: assert property (sfr_rd && hit_address |=> sfr_rdata[7:5] == 3'h0)
        else $error("address read shows upper bits set");

    control_upper_zero_a: assert property (sfr_rd && hit_control |=> sfr_rdata[7:4] == 4'h0)
        else $error("control read shows upper bits set");

    data_write_store_a: assert property (sfr_wr && hit_data && r.st == nvac_pkg::NVAC_IDLE
        |=> r.nvm_data == $past(sfr_wdata))
        else $error("data register did not take written byte");

    write_gate_a: assert property (sfr_wr && hit_control && !r.write_permit && r.st == nvac_pkg::NVAC_IDLE
        |=> !r.write_start)
        else $error("write started without prior permit");

    read_gate_a: assert property (sfr_wr && hit_control && !r.read_permit && r.st == nvac_pkg::NVAC_IDLE
        |=> !r.read_start)
        else $error("read started without prior permit");

    read_latency_a: assert property ($rose(r.read_start) |-> r.read_start [*2] ##1 !r.read_start)
        else $error("read cycle length wrong");

    read_result_a: assert property (read_commit |=> r.nvm_data == $past(mem_rdata) && !r.read_start)
        else $error("read result not placed in data register");

    write_permit_held_a: assert property (write_commit |-> r.write_permit && r.write_start)
        else $error("write committed without permit");

    write_done_flag_a: assert property (write_commit |=> write_done_irq_flag && !r.write_start)
        else $error("write end did not raise flag and clear start");

    write_tick_only_a: assert property (r.st == nvac_pkg::NVAC_WRITE && !slow_tick && r.write_permit
        |=> $stable(r.cnt) && r.write_start)
        else $error("write progressed without slow tick");

    data_hold_a: assert property (r.st == nvac_pkg::NVAC_IDLE && !(sfr_wr && hit_data) |=> $stable(r.nvm_data))
        else $error("data register changed while idle");

    read_done_c: cover property ($fell(r.read_start) && !r.busy);
    write_done_c: cover property (write_commit);
    blocked_write_c: cover property (sfr_wr && hit_control && sfr_wdata[2] && !r.write_permit);
    flag_cleared_c: cover property (write_done_irq_flag && irq_ack);

endmodule

/* File: shared/nvac_pkg.sv */
// constants and types shared by the non-volatile data access controller
package nvac_pkg;

    // ==========================================
    // geometry
    localparam int unsigned NVAC_DEPTH = 32;
    localparam int unsigned NVAC_DATA_W = 8;
    localparam int unsigned NVAC_ADDR_W = 5;

    // ==========================================
    // special register map (bank, offset)
    localparam logic NVAC_BANK_DIRECT = 1'b0;
    localparam logic NVAC_BANK_CTRL = 1'b1;
    localparam logic [7:0] NVAC_OFS_ADDRESS = 8'h2E;
    localparam logic [7:0] NVAC_OFS_DATA = 8'h2F;
    localparam logic [7:0] NVAC_OFS_CONTROL = 8'h40;

    // ==========================================
    // control register fields
    localparam int unsigned NVAC_BIT_WRITE_PERMIT = 3;
    localparam int unsigned NVAC_BIT_WRITE_START = 2;
    localparam int unsigned NVAC_BIT_READ_PERMIT = 1;
    localparam int unsigned NVAC_BIT_READ_START = 0;

    // ==========================================
    // reset values
    localparam logic [4:0] NVAC_RST_ADDRESS = 5'h00;
    localparam logic [7:0] NVAC_RST_DATA = 8'h00;
    localparam logic NVAC_RST_CTRL_BIT = 1'b0;

    // ==========================================
    // timing
    // read takes this many system clocks from launch to the start bit falling (at least 2)
    localparam logic [7:0] NVAC_READ_CYCLES = 8'h02;
    // default number of slow clock rising edges that a write lasts
    localparam logic [7:0] NVAC_WRITE_TICKS = 8'h04;

    // ==========================================
    // sequencer states
    typedef enum logic [2:0]
    {
        NVAC_IDLE = 3'b001,
        NVAC_READ = 3'b010,
        NVAC_WRITE = 3'b100
    } nvac_fsm_t;

endpackage

/* File: verilog/nvac_sync.sv */
// three-stage synchroniser with agreement filter and rising-edge pulse
`timescale 1ns/1ps

module nvac_sync
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic async_in,
    output logic rise_pulse
);

    typedef struct packed
    {
        logic s1;
        logic s2;
        logic s3;
        logic level;
        logic pulse;
    } nvac_sync_state_t;

    nvac_sync_state_t r;
    nvac_sync_state_t next_r;

    // ==========================================
    // filter
    always_comb
    begin
        next_r = r;
        next_r.s1 = async_in;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        next_r.pulse = 1'b0;
        if (r.s2 == r.s3)
        begin
            next_r.level = r.s3;
            next_r.pulse = r.s3 & ~r.level;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            r <= '0;
        else if (ce)
            r <= next_r;
    end

    assign rise_pulse = r.pulse;

endmodule

/* File: verilog/nvac_mem.sv */
// byte-wide storage array with registered read data
`timescale 1ns/1ps

module nvac_mem
#(
    parameter int unsigned DEPTH = nvac_pkg::NVAC_DEPTH,
    parameter int unsigned WIDTH = nvac_pkg::NVAC_DATA_W,
    parameter int unsigned AW = nvac_pkg::NVAC_ADDR_W
)
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [AW-1:0] addr,
    input wire logic [WIDTH-1:0] wdata,
    output logic [WIDTH-1:0] rdata
);

    typedef struct packed
    {
        logic [DEPTH-1:0][WIDTH-1:0] cells;
        logic [WIDTH-1:0] rdata;
    } nvac_mem_state_t;

    nvac_mem_state_t r;
    nvac_mem_state_t next_r;

    // ==========================================
    // access
    always_comb
    begin
        next_r = r;
        if (wr_en)
            next_r.cells[addr] = wdata;
        if (rd_en)
            next_r.rdata = r.cells[addr];
    end

    // contents survive reset on purpose: the array models non-volatile cells
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            r.rdata <= '0;
        else if (ce)
            r <= next_r;
    end

    assign rdata = r.rdata;

    default clocking mem_cb @(posedge clk);
    endclocking
    default disable iff (!reset_n || !ce);

    cell_write_a: assert property (wr_en |=> r.cells[$past(addr)] == $past(wdata))
        else $error("stored byte does not match written byte");

endmodule

/* File: verification/tb.sv */
// self-checking testbench for the non-volatile data access controller
`timescale 1ns/1ps

module tb;
    // ==========================================
    // signals and clocks
    logic clk;
    logic reset_n;
    logic sfr_bank;
    logic [7:0] sfr_addr;
    logic sfr_wr;
    logic sfr_rd;
    logic [7:0] sfr_wdata;
    logic [7:0] sfr_rdata;
    logic slow_clk_in;
    logic irq_ack;
    logic write_done_irq_flag;
    logic nvm_busy;
    int err_count;
    int n_compared;
    int cycles;
    logic ce;

    nvac_ctrl #(.WRITE_TICKS(8'h02)) i_nvac_ctrl
    (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .sfr_bank(sfr_bank),
        .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata),
        .slow_clk_in(slow_clk_in),
        .irq_ack(irq_ack),
        .write_done_irq_flag(write_done_irq_flag),
        .nvm_busy(nvm_busy)
    );

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // slow clock runs free and out of phase with the system clock
    // slow clock stable
    initial
    begin
        slow_clk_in = 1'b0;
        forever #733 slow_clk_in = ~slow_clk_in;
    end

    // ==========================================
    // bus tasks; each starts just after an edge; wr leaves its strobe up, rd drops it
    task automatic wr(input logic b, input logic [7:0] a, input logic [7:0] d);
        sfr_bank <= b;
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        sfr_rd <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic b, input logic [7:0] a, output logic [7:0] d);
        sfr_bank <= b;
        sfr_addr <= a;
        sfr_wr <= 1'b0;
        sfr_rd <= 1'b1;
        @(posedge clk);
        sfr_rd <= 1'b0;
        @(posedge clk);
        d = sfr_rdata;
    endtask

    task automatic idle(input int n);
        sfr_wr <= 1'b0;
        sfr_rd <= 1'b0;
        repeat (n) @(posedge clk);
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic rd_chk(input logic b, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(b, a, d);
        check(d, exp);
    endtask

    // polls control until the given start bit drops, within a bound of reads
    task automatic wait_clear(input int bit_no, input int limit);
        int k;
        logic [7:0] d;
        k = 0;
        rd(1'b1, 8'h40, d);
        while (d[bit_no] !== 1'b0 && k < limit)
        begin
            rd(1'b1, 8'h40, d);
            k++;
        end
        check({7'h00, d[bit_no]}, 8'h00);
    endtask

    task automatic do_write(input logic [7:0] a, input logic [7:0] d);
        wr(1'b0, 8'h2E, a);
        wr(1'b0, 8'h2F, d);
        wr(1'b1, 8'h40, 8'h08);
        wr(1'b1, 8'h40, 8'h0C);
        rd_chk(1'b1, 8'h40, 8'h0C);
        check({7'h00, nvm_busy}, 8'h01);
        wait_clear(2, 200);
        check({7'h00, write_done_irq_flag}, 8'h01);
        irq_ack <= 1'b1;
        @(posedge clk);
        irq_ack <= 1'b0;
        @(posedge clk);
        check({7'h00, write_done_irq_flag}, 8'h00);
        wr(1'b1, 8'h40, 8'h00);
    endtask

    task automatic do_read(input logic [7:0] a, input logic [7:0] exp);
        wr(1'b0, 8'h2F, 8'h00);
        wr(1'b0, 8'h2E, a);
        wr(1'b1, 8'h40, 8'h02);
        wr(1'b1, 8'h40, 8'h03);
        rd_chk(1'b1, 8'h40, 8'h03);
        wait_clear(0, 4);
        rd_chk(1'b0, 8'h2F, exp);
        check({7'h00, write_done_irq_flag}, 8'h00);
    endtask

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ==========================================
    // hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            wrap_up();
        end
    end

    // ==========================================
    // main sequence
    initial
    begin
        err_count = 0;
        n_compared = 0;
        cycles = 0;
        reset_n = 1'b0;
        sfr_bank = 1'b0;
        sfr_addr = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        sfr_wdata = 8'h00;
        irq_ack = 1'b0;
        ce = 1'b1;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);

        rd_chk(1'b0, 8'h2E, 8'h00);
        rd_chk(1'b0, 8'h2F, 8'h00);
        rd_chk(1'b1, 8'h40, 8'h00);
        check({6'h00, nvm_busy, write_done_irq_flag}, 8'h00);
        $display("end of test reset");

        wr(1'b0, 8'h2E, 8'hFF);
        rd_chk(1'b0, 8'h2E, 8'h1F);
        wr(1'b0, 8'h2F, 8'hA5);
        rd_chk(1'b0, 8'h2F, 8'hA5);
        wr(1'b1, 8'h40, 8'hF0);
        rd_chk(1'b1, 8'h40, 8'h00);
        wr(1'b0, 8'h40, 8'h0A);
        rd_chk(1'b1, 8'h40, 8'h00);
        rd_chk(1'b0, 8'h40, 8'h00);
        rd_chk(1'b1, 8'h2E, 8'h00);
        rd_chk(1'b0, 8'h30, 8'h00);
        $display("end of test registers");

        // starts refused without a stored permit
        // never both start bits in one write
        wr(1'b1, 8'h40, 8'h04);
        rd_chk(1'b1, 8'h40, 8'h00);
        wr(1'b1, 8'h40, 8'h03);
        rd_chk(1'b1, 8'h40, 8'h02);
        wr(1'b1, 8'h40, 8'h02);
        wr(1'b1, 8'h40, 8'h06);
        rd_chk(1'b1, 8'h40, 8'h02);
        wr(1'b1, 8'h40, 8'h00);
        $display("end of test refusals");

        // boundary locations 0x00 and 0x1F and location 0x03 written then read back
        do_write(8'h00, 8'h5A);
        do_write(8'h1F, 8'hA5);
        do_write(8'h03, 8'h3C);
        do_read(8'h00, 8'h5A);
        do_read(8'h1F, 8'hA5);
        do_read(8'h03, 8'h3C);
        idle(20);
        rd_chk(1'b0, 8'h2F, 8'h3C);
        $display("end of test write and read");

        // a cleared permit blocks the write, so nothing is stored
        wr(1'b0, 8'h2E, 8'h03);
        wr(1'b0, 8'h2F, 8'hC3);
        wr(1'b1, 8'h40, 8'h04);
        idle(80);
        check({7'h00, write_done_irq_flag}, 8'h00);
        rd_chk(1'b1, 8'h40, 8'h00);
        do_read(8'h03, 8'h3C);
        $display("end of test write blocked");

        // clearing the read permit ends the read before the byte lands
        wr(1'b0, 8'h2E, 8'h00);
        wr(1'b1, 8'h40, 8'h02);
        wr(1'b1, 8'h40, 8'h03);
        wr(1'b1, 8'h40, 8'h00);
        idle(1);
        rd_chk(1'b1, 8'h40, 8'h00);
        check({7'h00, nvm_busy}, 8'h00);
        rd_chk(1'b0, 8'h2F, 8'h3C);
        $display("end of test read abort");

        // clock enable low freezes every register; held two edges so no check sees a half-frozen cycle
        ce <= 1'b0;
        wr(1'b0, 8'h2F, 8'h11);
        idle(1);
        ce <= 1'b1;
        idle(1);
        rd_chk(1'b0, 8'h2F, 8'h3C);
        $display("end of test clock enable");

        idle(2);
        wrap_up();
    end
endmodule
